/* File: design/fbp_protect.sv */
`default_nettype none
module fbp_protect
   import fbp_pkg::*;
#(
   parameter int PROG_CYCLES  = PROG_CYCLES_D,
   parameter int ERASE_CYCLES = ERASE_CYCLES_D
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              link_sclk,
   input  wire logic              link_cs_n,
   input  wire logic              link_sdi,
   input  wire logic              hw_reset_n,
   input  wire logic              password_mode,
   input  wire logic              password_match,
   input  wire logic              factory_init,
   input  wire logic [ADDR_W-1:0] arr_addr,
   output logic                   arr_write_ok,
   output logic                   arr_read_ok
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: sclk, cs_n, sdi, hw_reset_n

   logic [3:0]           sync1;          // first stage, read only by sync2
   logic [3:0]           sync2;          // second stage
   logic [3:0]           sync3;          // third stage

   // three flops; a change counts once sync2 and sync3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 4'hf;
         sync2 <= 4'hf;
         sync3 <= 4'hf;
      end else if (ce) begin
         sync1 <= {hw_reset_n, link_sdi, link_cs_n, link_sclk};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   logic [3:0]           pins;           // settled pin levels

   // a level is taken over only once the second and third stages agree,
   // so a glitch caught by one stage alone never makes an edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= 4'hf;
      end else if (ce) begin
         pins <= (sync2 & sync3) | (pins & (sync2 | sync3));
      end
   end

   logic                 sclk_rise;      // agreed rising edge of link clock
   logic                 cs_rise;        // end of frame
   logic                 cs_fall;        // start of frame
   logic                 hwr_active;     // hardware reset pin held low
   assign sclk_rise  = sync2[0] && sync3[0] && !pins[0];
   assign cs_rise    = sync2[1] && sync3[1] && !pins[1];
   assign cs_fall    = !sync2[1] && !sync3[1] && pins[1];
   assign hwr_active = !sync2[3] && !sync3[3];

   ////////////////////////////////////////////////////////////////////////////
   // link frame receiver

   logic [FRAME_BITS-1:0] frame;         // shift register, msb first
   logic [5:0]            frame_cnt;     // bits taken in this frame
   logic                  link_en;       // ctrl register, link commands on

   // bits are sampled at sclk rising edges while cs_n is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame     <= '0;
         frame_cnt <= 6'h00;
      end else if (ce) begin
         if (cs_fall) begin
            frame_cnt <= 6'h00;
         end else if (sclk_rise && !pins[1] && frame_cnt != 6'h20) begin
            frame     <= {frame[FRAME_BITS-2:0], pins[2]};
            frame_cnt <= frame_cnt + 6'h01;
         end
      end
   end

   // a short frame is dropped; a long frame stops counting at 32 bits and launches its first 32
   logic                  link_go;
   assign link_go = cs_rise && frame_cnt == 6'h20 && link_en;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   logic                  apb_done;      // access phase completes this edge
   logic [ADDR_W-1:0]     addr_reg;      // command address register
   logic                  apb_go;        // command written over apb
   assign apb_done = psel && penable && pready;
   assign apb_go   = apb_done && pwrite && paddr == REG_CMD;

   // pready rises in the access phase, so every transfer takes no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= psel && !penable;
      end
   end

   // writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= '0;
         link_en  <= CTRL_RESET;
      end else if (ce && apb_done && pwrite) begin
         if (paddr == REG_ADDR) begin
            addr_reg <= pwdata[ADDR_W-1:0];
         end
         if (paddr == REG_CTRL) begin
            link_en <= pwdata[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command selection: apb wins when both arrive together

   logic                  cmd_go;
   logic [2:0]            cmd_op;
   logic [ADDR_W-1:0]     cmd_addr;
   logic                  cmd_bit;
   logic [BLK_W-1:0]      cmd_blk;
   always_comb begin
      cmd_go   = apb_go || link_go;
      cmd_op   = apb_go ? pwdata[CMD_OP_LSB +: 3] : frame[FR_OP_LSB +: 3];
      cmd_bit  = apb_go ? pwdata[CMD_BIT_POS] : frame[FR_BIT_POS];
      cmd_addr = apb_go ? addr_reg : frame[ADDR_W-1:0];
   end
   assign cmd_blk = cmd_addr[ADDR_W-1:BLK_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // protection storage

   // persistent_protect_bit and volatile_protect_bit, one each per block
   logic [NUM_BLOCKS-1:0] persistent_protect_bit;
   logic [NUM_BLOCKS-1:0] vpb;           // volatile_protect_bit per block
   logic                  gate;          // persistent_change_gate
   logic                  gate_load;     // power-up value still to be loaded
   fbp_state_t            state;
   logic [CNT_W-1:0]      cnt;           // operation timer
   logic [BLK_W-1:0]      op_blk;        // block held by the running op
   logic                  idle;
   assign idle = state == FBP_IDLE;

   // decoded one-shot actions: commands taken only when idle, then op completions
   logic                  do_vpb;
   logic                  do_soft;
   logic                  do_clear;
   logic                  do_unlock;
   logic                  prog_done;
   logic                  prep_done;
   logic                  erase_done;
   always_comb begin
      do_vpb     = cmd_go && idle && cmd_op == OP_WRITE_VPB;
      do_soft    = cmd_go && idle && cmd_op == OP_SOFT_RESET;
      do_clear   = cmd_go && idle && cmd_op == OP_CLEAR_GATE;
      do_unlock  = cmd_go && idle && cmd_op == OP_UNLOCK && password_mode && password_match;
      prog_done  = state == FBP_PROG && cnt == 24'h000001;
      prep_done  = state == FBP_PREP && cnt == 24'h000001;
      erase_done = state == FBP_ERASE && cnt == 24'h000001;
   end

   // non-volatile bits: no reset of any kind reaches them
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (factory_init) begin
            persistent_protect_bit <= '1;
         end else if (prog_done) begin
            persistent_protect_bit[op_blk] <= 1'b0;
         end else if (prep_done) begin
            persistent_protect_bit <= '0;
         end else if (erase_done) begin
            persistent_protect_bit <= '1;
         end
      end
   end

   // volatile bits come back unprotected on every reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vpb <= '1;
      end else if (ce) begin
         if (hwr_active || do_soft) begin
            vpb <= '1;
         end else if (do_vpb) begin
            vpb[cmd_blk] <= cmd_bit;
         end
      end
   end

   // gate: the mode strap is read one clock after reset release, since the
   // async branch may only load a constant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate      <= 1'b0;
         gate_load <= 1'b1;
      end else if (ce) begin
         gate_load <= 1'b0;
         if (gate_load || hwr_active) begin
            gate <= !password_mode;
         end else if (do_clear) begin
            gate <= 1'b0;
         end else if (do_unlock) begin
            gate <= 1'b1;
         end
         // software reset and all other commands leave the gate alone
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operation sequencer

   logic                  fail;          // last command failed or was refused
   logic                  addr_err;      // read not aimed at block byte zero
   logic                  ppb_val;       // result of the last read
   logic                  rd_valid;      // ppb_val holds a fresh result

   // one command at a time; a command arriving while busy is refused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= FBP_IDLE;
         cnt      <= '0;
         op_blk   <= '0;
         fail     <= 1'b0;
         addr_err <= 1'b0;
         ppb_val  <= 1'b1;
         rd_valid <= 1'b0;
      end else if (ce) begin
         if (hwr_active) begin
            // a hardware reset aborts the volatile sequencing; the stored
            // bits keep whatever state they had reached
            state <= FBP_IDLE;
            cnt   <= '0;
         end else unique case (state)
            FBP_IDLE: begin
               if (cmd_go) begin
                  fail     <= 1'b0;
                  addr_err <= 1'b0;
                  op_blk   <= cmd_blk;
                  unique case (cmd_op)
                     OP_READ_PPB: begin
                        rd_valid <= 1'b0;
                        if (cmd_addr[BLK_LSB-1:0] != '0) begin
                           addr_err <= 1'b1;
                           fail     <= 1'b1;
                        end else begin
                           state <= FBP_READ;
                           cnt   <= CNT_W'(READ_CYCLES);
                        end
                     end
                     OP_PROG_PPB: begin
                        if (!gate) begin
                           fail <= 1'b1;
                        end else begin
                           state <= FBP_PROG;
                           cnt   <= CNT_W'(PROG_CYCLES);
                        end
                     end
                     OP_ERASE_PPB: begin
                        // the address is ignored: erase is always global
                        if (!gate) begin
                           fail <= 1'b1;
                        end else begin
                           state <= FBP_PREP;
                           cnt   <= CNT_W'(PROG_CYCLES);
                        end
                     end
                     OP_UNLOCK: begin
                        fail <= !(password_mode && password_match);
                     end
                     default: begin
                        // volatile write, gate clear, soft reset, code 0
                     end
                  endcase
               end
            end
            FBP_READ: begin
               if (cnt == 24'h000001) begin
                  ppb_val  <= persistent_protect_bit[op_blk];
                  rd_valid <= 1'b1;
                  state    <= FBP_IDLE;
               end
               cnt <= cnt - 24'h000001;
            end
            FBP_PROG: begin
               if (cnt == 24'h000001) begin
                  state <= FBP_IDLE;
               end
               cnt <= cnt - 24'h000001;
            end
            FBP_PREP: begin
               // preprogram every bit to 0 before the erase pulse
               if (cnt == 24'h000001) begin
                  state <= FBP_ERASE;
                  cnt   <= CNT_W'(ERASE_CYCLES);
               end else begin
                  cnt <= cnt - 24'h000001;
               end
            end
            FBP_ERASE: begin
               if (cnt == 24'h000001) begin
                  state <= FBP_IDLE;
               end
               cnt <= cnt - 24'h000001;
            end
         endcase
         if (!idle && cmd_go) begin
            fail <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array-side permission outputs

   logic [BLK_W-1:0]      arr_blk;
   assign arr_blk = arr_addr[ADDR_W-1:BLK_LSB];

   // both bits must be 1 for the block to be writable; a busy sequencer
   // also holds off array writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_write_ok <= 1'b0;
         arr_read_ok  <= 1'b0;
      end else if (ce) begin
         arr_write_ok <= persistent_protect_bit[arr_blk] && vpb[arr_blk] && idle;
         arr_read_ok  <= state != FBP_PROG && !(state == FBP_IDLE && cmd_go
                         && cmd_op == OP_PROG_PPB && gate);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read data

   logic [31:0]           status;
   always_comb begin
      status              = '0;
      status[ST_BUSY]     = !idle;
      status[ST_GATE]     = gate;
      status[ST_FAIL]     = fail;
      status[ST_PPB_VAL]  = ppb_val;
      status[ST_RD_VALID] = rd_valid;
      status[ST_PWD_MODE] = password_mode;
      status[ST_PROG]     = state == FBP_PROG;
      status[ST_ERASE]    = state == FBP_PREP || state == FBP_ERASE;
      status[ST_ADDR_ERR] = addr_err;
   end

   // read data is loaded in the setup cycle so it stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         if (psel && !penable) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            unique case (paddr)
               REG_ADDR:   prdata <= {{(32-ADDR_W){1'b0}}, addr_reg};
               REG_STATUS: prdata <= status;
               REG_CTRL:   prdata <= {31'h00000000, link_en};
               REG_CMD:    prdata <= '0;
               default:    pslverr <= 1'b1;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_prog_start;
      ce && idle && cmd_go && cmd_op == OP_PROG_PPB && gate && !hwr_active;
   endsequence
   sequence s_read_start;
      ce && idle && cmd_go && cmd_op == OP_READ_PPB && cmd_addr[BLK_LSB-1:0] == '0
      && !hwr_active;
   endsequence

   a_gate_blocks_change: assert property (
      ce && idle && cmd_go && !gate && !hwr_active
      && (cmd_op == OP_PROG_PPB || cmd_op == OP_ERASE_PPB)
      |=> idle && fail && persistent_protect_bit == $past(persistent_protect_bit))
      else $error("persistent bits changed while gate closed");

   a_prog_to_zero: assert property (
      ce && prog_done && !factory_init && !hwr_active |=> !persistent_protect_bit[$past(op_blk)])
      else $error("programmed persistent bit not zero");

   a_erase_all_ones: assert property (
      ce && erase_done && !hwr_active |=> persistent_protect_bit == '1)
      else $error("erase left a persistent bit at zero");

   a_read_latency: assert property (
      s_read_start |=> !rd_valid && state == FBP_READ ##[1:12] rd_valid)
      else $error("persistent bit read latency wrong");

   a_prog_blocks_read: assert property (
      s_prog_start |=> !arr_read_ok ##1 !arr_read_ok)
      else $error("array read allowed during program");

   a_soft_keeps_gate: assert property (
      ce && do_soft && !hwr_active && !gate_load |=> gate == $past(gate) && vpb == '1)
      else $error("soft reset touched the gate");

   a_gate_stays_closed: assert property (
      !password_mode && !gate && !hwr_active && !gate_load |=> !gate)
      else $error("gate reopened without hardware reset");

   a_write_ok_combo: assert property (
      ce && idle && !(persistent_protect_bit[arr_blk] && vpb[arr_blk]) |=> !arr_write_ok)
      else $error("protected block reported writable");

   a_pwd_unlock_only: assert property (
      password_mode && !gate && !hwr_active && !gate_load && !do_unlock |=> !gate)
      else $error("gate opened without password unlock");

   a_status_busy: assert property (
      s_prog_start |=> status[ST_BUSY] && status[ST_PROG])
      else $error("busy not reported during program");

endmodule
`default_nettype wire

/* File: design/fbp_pkg.sv */
// How it works
// - 512 blocks, each persistent and volatile bit
// - block index is byte address over 256 KB
// - persistent bits survive every kind of reset
// - program one bit to 0, erase all to 1
// - erase preprograms all bits to 0 internally first
// - program ~page time, erase ~sector time
// - busy and phase visible in status register
// - no array reads while persistent bit programs
// - dedicated read returns one block's persistent bit
// - persistent bit read costs initial access time
// - erase is global, takes no block address
// - delivered parts hold every persistent bit at 1
// - volatile bit write: 0 protects, 1 unprotects
// - volatile bit matters only if persistent is 1
// - gate 0 freezes persistent bits, 1 allows
// - gated program or erase fails, changes nothing
// - persistent mode: gate 1 at reset, sticky 0
// - password mode: gate 0, only unlock sets
// - unprotected only when both bits are 1
// - volatile bits return to 1 on resets
// - software reset leaves the gate untouched
`default_nettype none
package fbp_pkg;
   localparam int          NUM_BLOCKS     = 512;      // 256 KB blocks in 1 Gbit
   localparam int          BLK_W          = 9;        // block index width
   localparam int          ADDR_W         = 27;       // byte address width
   localparam int          BLK_LSB        = 18;       // 256 KB = 2**18 bytes
   localparam int          CNT_W          = 24;       // operation timer width
   // timing
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          PROG_TIME_NS   = 200000;   // page program, typical
   localparam int          ERASE_TIME_NS  = 40000000; // sector erase, typical
   localparam int          READ_TIME_NS   = 40;       // initial access time
   localparam int          PROG_CYCLES_D  = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int          ERASE_CYCLES_D = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int          READ_CYCLES    = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register offsets
   localparam logic [7:0]  REG_CMD        = 8'h00;
   localparam logic [7:0]  REG_ADDR       = 8'h04;
   localparam logic [7:0]  REG_STATUS     = 8'h08;
   localparam logic [7:0]  REG_CTRL       = 8'h0c;
   localparam logic [0:0]  CTRL_RESET     = 1'h0;     // link commands off
   // command field layout (cmd register and link frame top bits)
   localparam int          CMD_OP_LSB     = 0;
   localparam int          CMD_BIT_POS    = 3;
   localparam int          FRAME_BITS     = 32;
   localparam int          FR_OP_LSB      = 29;
   localparam int          FR_BIT_POS     = 28;
   // command codes
   localparam logic [2:0]  OP_READ_PPB    = 3'h1;
   localparam logic [2:0]  OP_PROG_PPB    = 3'h2;
   localparam logic [2:0]  OP_ERASE_PPB   = 3'h3;
   localparam logic [2:0]  OP_WRITE_VPB   = 3'h4;
   localparam logic [2:0]  OP_CLEAR_GATE  = 3'h5;
   localparam logic [2:0]  OP_UNLOCK      = 3'h6;
   localparam logic [2:0]  OP_SOFT_RESET  = 3'h7;
   // status bit positions
   localparam int          ST_BUSY        = 0;
   localparam int          ST_GATE        = 1;
   localparam int          ST_FAIL        = 2;
   localparam int          ST_PPB_VAL     = 3;
   localparam int          ST_RD_VALID    = 4;
   localparam int          ST_PWD_MODE    = 5;
   localparam int          ST_PROG        = 6;
   localparam int          ST_ERASE       = 7;
   localparam int          ST_ADDR_ERR    = 8;
   typedef enum logic [2:0] {
      FBP_IDLE, FBP_READ, FBP_PROG, FBP_PREP, FBP_ERASE
   } fbp_state_t;
endpackage
`default_nettype wire

/* File: verif/fbp_link_host.sv */
`default_nettype none
// far-side host: clocks 32-bit command frames into the link pins
module fbp_link_host (
   output var logic link_sclk,  // stands low outside frames
   output var logic link_cs_n,  // frame select, idle high
   output var logic link_sdi    // msb first, set while clock low
);
   timeunit 1ns;
   timeprecision 1ps;
   //////////////////////////////////////////////////////////////////
   // one frame at a 32 ns clock; callers address block byte zero
   task automatic send(input logic [31:0] f);
      link_cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         link_sdi = f[i];
         #16 link_sclk = 1'b1;
         #16 link_sclk = 1'b0;
      end
      #8 link_cs_n = 1'b1;
      // released line must not keep showing the last bit
      link_sdi = ~link_sdi;
      #40;
   endtask
   // idle levels from time zero
   initial begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      link_sdi  = 1'b0;
   end
endmodule
`default_nettype wire

/* File: verif/tb_flash_block_protection_bits.sv */
`default_nettype none
module tb_flash_block_protection_bits;
   import fbp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;                   // apb byte address
   logic [31:0] pwdata, prdata, rv;      // bus data, last read
   logic        errv;                    // last slave error
   logic link_sclk, link_cs_n, link_sdi, hw_reset_n, password_mode;
   logic password_match, factory_init, arr_write_ok, arr_read_ok;
   logic [ADDR_W-1:0] arr_addr;          // array query address
   int n_mismatch = 0;
   int checked = 0;
   // short counts keep the run small
   fbp_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) dut_u (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_sdi(link_sdi),
      .hw_reset_n(hw_reset_n), .password_mode(password_mode),
      .password_match(password_match), .factory_init(factory_init),
      .arr_addr(arr_addr), .arr_write_ok(arr_write_ok),
      .arr_read_ok(arr_read_ok));
   fbp_link_host host_u (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
      .link_sdi(link_sdi));
   //////////////////////////////////////////////////////////////////
   // 250 MHz clock
   always #2 pclk = ~pclk;
   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // apb transfer: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count is assumed; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [ADDR_W-1:0] ba(input int n);
      return ADDR_W'(n << BLK_LSB);
   endfunction
   task automatic cmd(input logic [2:0] op, input logic b, input logic [ADDR_W-1:0] a);
      apb(1'b1, REG_ADDR, 32'(a));
      apb(1'b1, REG_CMD, {28'h0, b, op});
   endtask
   // poll until the sequencer is idle, bounded
   task automatic wt;
      int i;
      for (i = 0; i < 200; i++) begin
         apb(1'b0, REG_STATUS, 32'h0);
         if (rv[ST_BUSY] === 1'b0) break;
      end
      if (i == 200) chk(32'h1, 32'h0);
   endtask
   task automatic st(input int b, input logic e);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rv[b]), 32'(e));
   endtask
   task automatic ppb_chk(input int n, input logic e);
      cmd(OP_READ_PPB, 1'b0, ba(n));
      wt;
      chk(32'(rv[ST_PPB_VAL]), 32'(e));
   endtask
   task automatic wok(input int n, input logic e);
      arr_addr <= ba(n);
      repeat (2) @(posedge pclk);
      #1 chk(32'(arr_write_ok), 32'(e));
   endtask
   task automatic hrst;
      hw_reset_n <= 1'b0;
      repeat (6) @(posedge pclk);
      hw_reset_n <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask
   //////////////////////////////////////////////////////////////////
   // watchdog: the tests need well under 20 us
   initial begin
      #100000;
      n_mismatch++;
      results;
   end
   // main sequence
   initial begin
      pclk = 0;
      presetn = 0;
      ce = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      hw_reset_n = 1;
      password_mode = 0;
      password_match = 0;
      factory_init = 0;
      arr_addr = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      factory_init <= 1'b1;
      @(posedge pclk);
      factory_init <= 1'b0;
      st(ST_GATE, 1'b1);
      ppb_chk(3, 1'b1);
      cmd(OP_PROG_PPB, 1'b0, ba(3));
      @(posedge pclk);
      #1 chk(32'(arr_read_ok), 32'h0);
      wt;
      ppb_chk(3, 1'b0);
      ppb_chk(4, 1'b1);
      wok(3, 1'b0);
      wok(4, 1'b1);
      $display("test program done");
      apb(1'b1, REG_CTRL, 32'h1);
      arr_addr <= ba(4);
      host_u.send({OP_WRITE_VPB, 2'b00, ba(4)});
      for (int i = 0; i < 40 && arr_write_ok !== 1'b0; i++) @(posedge pclk);
      chk(32'(arr_write_ok), 32'h0);
      cmd(OP_WRITE_VPB, 1'b1, ba(4));
      wok(4, 1'b1);
      cmd(OP_WRITE_VPB, 1'b1, ba(3));
      wok(3, 1'b0);
      cmd(OP_WRITE_VPB, 1'b0, ba(4));
      wok(4, 1'b0);
      cmd(OP_SOFT_RESET, 1'b0, ba(0));
      wok(4, 1'b1);
      $display("test volatile done");
      cmd(OP_ERASE_PPB, 1'b0, ba(5));
      // a low enable must hold the erase where it stands, past its length
      ce <= 1'b0;
      repeat (80) @(posedge pclk);
      ce <= 1'b1;
      st(ST_BUSY, 1'b1);
      wt;
      ppb_chk(3, 1'b1);
      cmd(OP_PROG_PPB, 1'b0, ba(9));
      wt;
      cmd(OP_CLEAR_GATE, 1'b0, ba(0));
      st(ST_GATE, 1'b0);
      cmd(OP_PROG_PPB, 1'b0, ba(7));
      wt;
      chk(32'(rv[ST_FAIL]), 32'h1);
      ppb_chk(7, 1'b1);
      cmd(OP_UNLOCK, 1'b0, ba(0));
      st(ST_GATE, 1'b0);
      cmd(OP_SOFT_RESET, 1'b0, ba(0));
      st(ST_GATE, 1'b0);
      hrst;
      st(ST_GATE, 1'b1);
      ppb_chk(9, 1'b0);
      $display("test gate done");
      password_mode <= 1'b1;
      hrst;
      st(ST_GATE, 1'b0);
      cmd(OP_UNLOCK, 1'b0, ba(0));
      st(ST_GATE, 1'b0);
      password_match <= 1'b1;
      cmd(OP_UNLOCK, 1'b0, ba(0));
      st(ST_GATE, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(errv), 32'h1);
      $display("test password done");
      // power-up again in password mode: gate closed, stored bits kept
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      st(ST_GATE, 1'b0);
      ppb_chk(9, 1'b0);
      wok(4, 1'b1);
      $display("test power-up done");
      results;
   end
endmodule
`default_nettype wire
